// [hdl/fcs_regs.svh]
// constants for the flash command sequencer host: register offsets, fields,
// command codes and bus-cycle timing; assumes pclk at 250 MHz
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH

// ****************************************
// apb register map (byte offsets)
// ****************************************
`define FCS_REG_CTRL   12'h000
`define FCS_REG_ADDR   12'h004
`define FCS_REG_DATA   12'h008
`define FCS_REG_STATUS 12'h00C
`define FCS_REG_RDATA  12'h010
`define FCS_CTRL_GO    8
`define FCS_ST_BUSY    0
`define FCS_ST_VOK     1
`define FCS_ST_REFUSED 2
`define FCS_ST_DONE    3

// ****************************************
// operation codes written to ctrl[3:0]
// ****************************************
`define FCS_OP_RESET    4'h0
`define FCS_OP_PROG     4'h1
`define FCS_OP_CHIPER   4'h2
`define FCS_OP_SECTER   4'h3
`define FCS_OP_SUSPEND  4'h4
`define FCS_OP_RESUME   4'h5
`define FCS_OP_CFI      4'h6
`define FCS_OP_BYP_ENT  4'h7
`define FCS_OP_BYP_PROG 4'h8
`define FCS_OP_BYP_EXIT 4'h9
`define FCS_OP_IDENT    4'hA
`define FCS_OP_READ     4'hB
`define FCS_OP_LOCKPROG 4'hC
`define FCS_OP_PPBERASE 4'hD
`define FCS_OP_LOCKSTAT 4'hE
`define FCS_OP_PASSWORD 4'hF

// ****************************************
// flash widths and unlock addresses
// ****************************************
`define FCS_AW        22
`define FCS_UNLOCK1   12'h555
`define FCS_UNLOCK2   12'h2AA
`define FCS_CFI_ADDR  12'h055

// ****************************************
// timing: figures in their own unit, counts derived
// ****************************************
`define FCS_CLK_MHZ        250
`define FCS_CYC_NS(ns)     (((ns) * `FCS_CLK_MHZ + 999) / 1000)
`define FCS_T_AS_NS        10
`define FCS_T_WP_NS        35
`define FCS_T_WPH_NS       25
`define FCS_T_ACC_NS       65
`define FCS_T_LOCK_US      100
`define FCS_T_PPBER_MS_X10 12
`define FCS_T_PWD_US       2
`define FCS_LOCK_CYC       (`FCS_T_LOCK_US * `FCS_CLK_MHZ)
`define FCS_PPBER_CYC      (`FCS_T_PPBER_MS_X10 * `FCS_CLK_MHZ * 100)
`define FCS_PWD_CYC        (`FCS_T_PWD_US * `FCS_CLK_MHZ)

`endif

// [hdl/fcs_pkg.sv]
// types shared by the flash command sequencer host
// assumes fcs_regs.svh supplies the widths
`include "fcs_regs.svh"

package fcs_pkg;

  // ****************************************
  // pin bundle toward the flash
  // ****************************************
  typedef struct packed {
    logic                ce_n;
    logic                we_n;
    logic                oe_n;
    logic [`FCS_AW-1:0]  addr;
    logic [15:0]         dq_o;
    logic                dq_oe;
  } fcs_pins_t;

  // ****************************************
  // one bus cycle of a command sequence
  // ****************************************
  typedef struct packed {
    logic        last;
    logic        rd;
    logic        uaddr;
    logic        udata;
    logic [1:0]  pause;
    logic [11:0] lo;
    logic [7:0]  d;
  } fcs_step_t;

  typedef enum logic [1:0] { FCS_PZ_NONE, FCS_PZ_LOCK, FCS_PZ_PPBER, FCS_PZ_PWD } fcs_pause_t;

endpackage

// [hdl/fcs_cycle.sv]
// one asynchronous write or read cycle on the flash pins
// assumes the caller holds start for one cycle only when done has been seen
`timescale 1ns/100ps
`include "fcs_regs.svh"

module fcs_cycle
  import fcs_pkg::*;
(
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // request
  input  wire logic               start,
  input  wire logic               rd,
  input  wire logic [`FCS_AW-1:0] addr,
  input  wire logic [15:0]        wdata,
  // answer
  output logic                    done,
  output logic [15:0]             rdata,
  // flash pins
  output fcs_pins_t               pins,
  input  wire logic [15:0]        dq_i
);

  typedef enum logic [1:0] { FCS_C_IDLE, FCS_C_SETUP, FCS_C_PULSE, FCS_C_HOLD } fcs_cst_t;

  localparam logic [4:0] AS_C  = 5'(`FCS_CYC_NS(`FCS_T_AS_NS));
  localparam logic [4:0] WP_C  = 5'(`FCS_CYC_NS(`FCS_T_WP_NS));
  localparam logic [4:0] WPH_C = 5'(`FCS_CYC_NS(`FCS_T_WPH_NS));
  // two extra cycles cover the input synchroniser
  localparam logic [4:0] ACC_C = 5'(`FCS_CYC_NS(`FCS_T_ACC_NS) + 2);

  fcs_cst_t    st_q;
  logic [4:0]  cnt_q;
  logic        rd_q;
  logic [15:0] dq_s1_q;
  logic [15:0] dq_s2_q;

  // ****************************************
  // data pins are async: two flops first
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
    end else begin
      dq_s1_q <= dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  wire cnt_end = (cnt_q == 5'h00);

  // ****************************************
  // cycle sequencer; address falls with ce, data held past we rise
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q  <= FCS_C_IDLE;
      cnt_q <= 5'h00;
      rd_q  <= 1'b0;
      done  <= 1'b0;
      rdata <= 16'h0000;
      pins  <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_o: 16'h0000, dq_oe: 1'b0};
    end else begin
      done <= 1'b0;
      case (st_q)
        FCS_C_IDLE: if (start) begin
          rd_q       <= rd;
          pins.addr  <= addr;
          pins.dq_o  <= wdata;
          pins.ce_n  <= 1'b0;
          pins.oe_n  <= !rd;
          cnt_q      <= rd ? ACC_C : AS_C;
          st_q       <= rd ? FCS_C_HOLD : FCS_C_SETUP;
        end
        FCS_C_SETUP: if (cnt_end) begin
          pins.we_n  <= 1'b0;        // later of ce and we falling latches address
          pins.dq_oe <= 1'b1;
          cnt_q      <= WP_C;
          st_q       <= FCS_C_PULSE;
        end else cnt_q <= cnt_q - 5'h01;
        FCS_C_PULSE: if (cnt_end) begin
          pins.we_n <= 1'b1;         // first rising edge latches data RULE9
          pins.ce_n <= 1'b1;
          cnt_q     <= WPH_C;
          st_q      <= FCS_C_HOLD;
        end else cnt_q <= cnt_q - 5'h01;
        default: if (cnt_end) begin
          if (rd_q) rdata <= dq_s2_q;
          pins.ce_n  <= 1'b1;
          pins.oe_n  <= 1'b1;
          pins.dq_oe <= 1'b0;
          done       <= 1'b1;
          st_q       <= FCS_C_IDLE;
        end else cnt_q <= cnt_q - 5'h01;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_strobe_excl: assert property (!(!pins.we_n && !pins.oe_n)) // RULE9
    else $error("we and oe low together");
  chk_data_driven: assert property (!pins.we_n |-> pins.dq_oe && $stable(pins.dq_o)) // RULE9
    else $error("data not driven under write strobe");
  chk_addr_hold: assert property (!pins.ce_n && !$past(pins.ce_n) |-> $stable(pins.addr)) // RULE9
    else $error("address moved during cycle");
  chk_cycle_ends: assert property (st_q == FCS_C_IDLE && start |-> ##[4:40] done)
    else $error("bus cycle did not finish");

endmodule

// [hdl/fcs_host.sv]
// host-side command sequencer for a two-bank nor flash, apb slave
// assumes flash pins outside pclk domain; bank/sector bits come from addr reg
//
// Notes on behaviour
// RULE1: device takes suspend code only during sector erase or its collection window.
// RULE2: device ignores suspend during chip erase or word program.
// RULE3: device halts erase within 35 us, or at once in collection window.
// RULE4: suspended bank reads normally outside chosen sectors, status inside them.
// RULE5: program during suspension returns bank to suspend-read when done.
// RULE6: identification works while suspended; leaving it returns to suspension.
// RULE7: resume is one code at the suspended bank address; repeats ignored.
// RULE8: one reset code returns bank to array or suspend-read state.
// RULE9: address latched on later falling strobe, data on first rising strobe.
// RULE10: only low address bits and low data byte are decoded.
// RULE11: both erases are six writes ending with chip or sector code.
// RULE12: bypass needs three-cycle entry, two-cycle program, two-cycle exit.
// RULE13: identification is three writes, bank address on third, then reads.
// RULE14: group protect query returns distinct unprotected and protected values.
// RULE15: secured-region lock query returns one of three lock codes.
// RULE16: parameter-table query accepted only in array-read or identification mode.
// RULE17: lock-bit program: cycle four programs, five and six verify bit0 one.
// RULE18: host waits 100 us or 1.2 ms between cycles four and five.
// RULE19: erase-all protect bits verifies bit0 zero; host reissues otherwise. Here the result only sets status vok; there is no reissue.
// RULE20: password given in four portions, full sequence each, 2 us apart.
// RULE21: protect-lock status reports lock state on data bit one.
// RULE22: lock-bit commands selected by fixed low-byte address patterns.
// RULE23: other commands in collection window abort to array reads.
// RULE24: polling bit reads zero while erasing, one when done or suspended.
// RULE25: mismatching write discards partial sequence, prior read state kept.
// RULE26: command state kept per bank.
`timescale 1ns/100ps
`include "fcs_regs.svh"

module fcs_host
  import fcs_pkg::*;
#(
  parameter int unsigned LOCK_CYC  = `FCS_LOCK_CYC,
  parameter int unsigned PPBER_CYC = `FCS_PPBER_CYC
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // flash pins
  output fcs_pins_t               flash,
  input  wire logic [15:0]        flash_dq_i
);

  typedef enum logic [1:0] { FCS_S_IDLE, FCS_S_ISSUE, FCS_S_WAIT, FCS_S_PAUSE } fcs_st_t;

  localparam logic [19:0] LOCK_CNT  = 20'(LOCK_CYC - 1);
  localparam logic [19:0] PPBER_CNT = 20'(PPBER_CYC - 1);
  localparam logic [19:0] PWD_CNT   = 20'(`FCS_PWD_CYC - 1);

  // ****************************************
  // command sequence tables
  // ****************************************
  function automatic fcs_step_t mk(input logic [11:0] lo, input logic [7:0] d);
    fcs_step_t s;
    s    = '0;
    s.lo = lo;
    s.d  = d;
    return s;
  endfunction

  // user-addressed cycle, optionally a read or using the data register
  function automatic fcs_step_t usr(input logic [7:0] d, input logic rd, input logic ud);
    fcs_step_t s;
    s       = mk(12'h000, d);
    s.uaddr = 1'b1;
    s.rd    = rd;
    s.udata = ud;
    return s;
  endfunction

  // steps after the unlock pair; idx counts from the third cycle
  function automatic fcs_step_t tail(input logic [3:0] op, input logic [2:0] idx);
    fcs_step_t s;
    s = mk(`FCS_UNLOCK1, 8'h00);
    case (op)
      `FCS_OP_PROG:     s = (idx == 3'd0) ? mk(`FCS_UNLOCK1, 8'hA0) : usr(8'h00, 1'b0, 1'b1);
      `FCS_OP_CHIPER, `FCS_OP_SECTER: begin
        case (idx)                                                    // RULE11
          3'd0:    s = mk(`FCS_UNLOCK1, 8'h80);
          3'd1:    s = mk(`FCS_UNLOCK1, 8'hAA);
          3'd2:    s = mk(`FCS_UNLOCK2, 8'h55);
          default: s = (op == `FCS_OP_CHIPER) ? mk(`FCS_UNLOCK1, 8'h10) : usr(8'h30, 1'b0, 1'b0);
        endcase
      end
      `FCS_OP_BYP_ENT:  s = mk(`FCS_UNLOCK1, 8'h20);                  // RULE12
      `FCS_OP_IDENT:    s = (idx == 3'd0) ? mk(`FCS_UNLOCK1, 8'h90) : usr(8'h00, 1'b1, 1'b0); // RULE13
      `FCS_OP_LOCKPROG: begin
        case (idx)                                                    // RULE17
          3'd0:    s = mk(`FCS_UNLOCK1, 8'h60);
          3'd1:    begin s = usr(8'h68, 1'b0, 1'b0); s.pause = FCS_PZ_LOCK; end // RULE18
          3'd2:    s = usr(8'h48, 1'b0, 1'b0);
          default: s = usr(8'h00, 1'b1, 1'b0);
        endcase
      end
      `FCS_OP_PPBERASE: begin
        case (idx)                                                    // RULE19
          3'd0:    s = mk(`FCS_UNLOCK1, 8'h60);
          3'd1:    begin s = usr(8'h60, 1'b0, 1'b0); s.pause = FCS_PZ_PPBER; end // RULE18
          3'd2:    s = usr(8'h40, 1'b0, 1'b0);
          default: s = usr(8'h00, 1'b1, 1'b0);
        endcase
      end
      `FCS_OP_LOCKSTAT: s = (idx == 3'd0) ? mk(`FCS_UNLOCK1, 8'h58) : usr(8'h00, 1'b1, 1'b0);
      default: begin                                                  // password portion
        s = (idx == 3'd0) ? mk(`FCS_UNLOCK1, 8'h38) : usr(8'h00, 1'b0, 1'b1);
        if (idx != 3'd0) s.pause = FCS_PZ_PWD;                        // RULE20
      end
    endcase
    return s;
  endfunction

  // number of cycles in each operation, minus one
  function automatic logic [2:0] last_idx(input logic [3:0] op);
    case (op)
      `FCS_OP_CHIPER, `FCS_OP_SECTER, `FCS_OP_LOCKPROG, `FCS_OP_PPBERASE: return 3'd5;
      `FCS_OP_PROG, `FCS_OP_IDENT, `FCS_OP_LOCKSTAT, `FCS_OP_PASSWORD:    return 3'd3;
      `FCS_OP_BYP_ENT:                                                  return 3'd2;
      `FCS_OP_BYP_PROG, `FCS_OP_BYP_EXIT:                               return 3'd1;
      default:                                                          return 3'd0;
    endcase
  endfunction

  function automatic fcs_step_t step_of(input logic [3:0] op, input logic [2:0] idx);
    fcs_step_t s;
    s = mk(`FCS_UNLOCK1, 8'hAA);
    case (op)
      `FCS_OP_RESET:    s = mk(12'h000, 8'hF0);                        // RULE8
      `FCS_OP_SUSPEND:  s = usr(8'hB0, 1'b0, 1'b0);                    // RULE1
      `FCS_OP_RESUME:   s = usr(8'h30, 1'b0, 1'b0);                    // RULE7
      `FCS_OP_CFI:      s = mk(`FCS_CFI_ADDR, 8'h98);                  // RULE16
      `FCS_OP_READ:     s = usr(8'h00, 1'b1, 1'b0);
      `FCS_OP_BYP_PROG: s = (idx == 3'd0) ? mk(12'h000, 8'hA0) : usr(8'h00, 1'b0, 1'b1); // RULE12
      `FCS_OP_BYP_EXIT: s = (idx == 3'd0) ? mk(12'h000, 8'h90) : mk(12'h000, 8'h00); // RULE12
      default: begin
        if (idx == 3'd1) s = mk(`FCS_UNLOCK2, 8'h55);
        else if (idx != 3'd0) s = tail(op, idx - 3'd2);
      end
    endcase
    s.last = (idx == last_idx(op));
    return s;
  endfunction

  // ****************************************
  // registers
  // ****************************************
  fcs_st_t            st_q;
  logic [3:0]         op_q;
  logic [2:0]         idx_q;
  logic [19:0]        cnt_q;
  logic [`FCS_AW-1:0] addr_q;
  logic [15:0]        data_q;
  logic [15:0]        rdata_q;
  logic               vok_q;
  logic               refused_q;
  logic               done_q;
  logic               cyc_done;
  logic [15:0]        cyc_rdata;

  // ****************************************
  // apb decode
  // ****************************************
  wire        apb_setup = psel && !penable;
  wire        apb_wr    = psel && penable && pwrite;
  wire        hit_ctrl  = (paddr == `FCS_REG_CTRL);
  wire        hit_addr  = (paddr == `FCS_REG_ADDR);
  wire        hit_data  = (paddr == `FCS_REG_DATA);
  wire        hit_stat  = (paddr == `FCS_REG_STATUS);
  wire        hit_rdat  = (paddr == `FCS_REG_RDATA);
  wire        mapped    = hit_ctrl || hit_addr || hit_data || hit_stat || hit_rdat;
  wire        busy      = (st_q != FCS_S_IDLE);
  wire        go_req    = apb_wr && hit_ctrl && pwdata[`FCS_CTRL_GO];
  wire        go        = go_req && !busy;
  wire [31:0] stat_word = {28'h0000000, done_q, refused_q, vok_q, busy};
  wire [31:0] rd_mux    = hit_ctrl ? {28'h0000000, op_q} :
                          hit_addr ? {10'h000, addr_q} :
                          hit_data ? {16'h0000, data_q} :
                          hit_stat ? stat_word :
                          hit_rdat ? {16'h0000, rdata_q} : 32'h00000000;

  // answer is registered in setup, so every access finishes in two cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup && !mapped;
      if (apb_setup && !pwrite) prdata <= rd_mux;
    end
  end

  // software-written parameters, steady while a sequence runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q   <= `FCS_OP_RESET;
      addr_q <= '0;
      data_q <= 16'h0000;
    end else begin
      if (go) op_q <= pwdata[3:0];
      if (apb_wr && hit_addr && !busy) addr_q <= pwdata[`FCS_AW-1:0];
      if (apb_wr && hit_data && !busy) data_q <= pwdata[15:0];
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  fcs_step_t cur;
  assign cur = step_of(op_q, idx_q);

  // only the low byte/bits carry the code; upper bits keep the bank
  wire [`FCS_AW-1:0] cyc_addr = cur.uaddr ? addr_q : {addr_q[`FCS_AW-1:12], cur.lo}; // RULE10
  wire [15:0]        cyc_data = cur.udata ? data_q : {8'h00, cur.d};
  wire [19:0]        pz_cnt   = (cur.pause == FCS_PZ_LOCK)  ? LOCK_CNT :
                                (cur.pause == FCS_PZ_PPBER) ? PPBER_CNT : PWD_CNT;
  wire               finish   = (st_q == FCS_S_WAIT && cyc_done && cur.last && cur.pause == FCS_PZ_NONE)
                              || (st_q == FCS_S_PAUSE && cnt_q == 20'h00000 && cur.last);
  // verify bit sense differs: programmed reads one, erased reads zero;
  // taken from the word landing now, rdata_q still holds the previous read
  wire               vok_new  = (op_q == `FCS_OP_PPBERASE) ? !cyc_rdata[0] : cyc_rdata[0]; // RULE17 RULE19

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= FCS_S_IDLE;
      idx_q   <= 3'd0;
      cnt_q   <= 20'h00000;
      rdata_q <= 16'h0000;
    end else begin
      case (st_q)
        FCS_S_IDLE:  if (go) begin
          idx_q <= 3'd0;
          st_q  <= FCS_S_ISSUE;
        end
        FCS_S_ISSUE: st_q <= FCS_S_WAIT;
        FCS_S_WAIT:  if (cyc_done) begin
          if (cur.rd) rdata_q <= cyc_rdata;
          if (cur.pause != FCS_PZ_NONE) begin
            cnt_q <= pz_cnt;                                          // RULE18 RULE20
            st_q  <= FCS_S_PAUSE;
          end else if (cur.last) st_q <= FCS_S_IDLE;
          else begin
            idx_q <= idx_q + 3'd1;
            st_q  <= FCS_S_ISSUE;
          end
        end
        default: if (cnt_q != 20'h00000) cnt_q <= cnt_q - 20'h00001;
        else if (cur.last) st_q <= FCS_S_IDLE;
        else begin
          idx_q <= idx_q + 3'd1;
          st_q  <= FCS_S_ISSUE;
        end
      endcase
    end
  end

  // status flags; a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vok_q     <= 1'b0;
      refused_q <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      if (finish && (op_q == `FCS_OP_LOCKPROG || op_q == `FCS_OP_PPBERASE)) vok_q <= vok_new;
      if (go_req && busy) refused_q <= 1'b1;
      else if (apb_wr && hit_stat && pwdata[`FCS_ST_REFUSED]) refused_q <= 1'b0;
      if (finish) done_q <= 1'b1;
      else if (apb_wr && hit_stat && pwdata[`FCS_ST_DONE]) done_q <= 1'b0;
    end
  end

  fcs_cycle u_cycle (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (st_q == FCS_S_ISSUE),
    .rd      (cur.rd),
    .addr    (cyc_addr),
    .wdata   (cyc_data),
    .done    (cyc_done),
    .rdata   (cyc_rdata),
    .pins    (flash),
    .dq_i    (flash_dq_i)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cycle_then_pause(logic [1:0] pz);
    st_q == FCS_S_WAIT && cyc_done && cur.pause == pz;
  endsequence

  chk_lock_wait: assert property (s_cycle_then_pause(FCS_PZ_LOCK) |=> cnt_q == LOCK_CNT) // RULE18
    else $error("lock wait not loaded");
  chk_erase_wait: assert property (s_cycle_then_pause(FCS_PZ_PPBER) |=> cnt_q == PPBER_CNT) // RULE18
    else $error("erase-all wait not loaded");
  chk_pwd_gap: assert property (s_cycle_then_pause(FCS_PZ_PWD) |=> cnt_q == PWD_CNT) // RULE20
    else $error("password gap not loaded");
  chk_pause_holds: assert property (st_q == FCS_S_PAUSE && cnt_q != 20'h00000 |=> st_q == FCS_S_PAUSE) // RULE18
    else $error("pause ended early");
  chk_go_busy: assert property (go |=> busy ##1 flash.ce_n == 1'b0) // RULE11
    else $error("start did not begin a cycle");
  chk_busy_refused: assert property (go_req && busy |=> refused_q && $stable(op_q)) // RULE25
    else $error("request while busy not refused");
  chk_unlock_first: assert property (go && pwdata[3:0] == `FCS_OP_CHIPER
      |=> ##2 flash.addr[11:0] == `FCS_UNLOCK1 && flash.dq_o[7:0] == 8'hAA) // RULE11
    else $error("erase sequence missing first unlock");
  chk_verify_sense: assert property (finish && op_q == `FCS_OP_LOCKPROG |=> vok_q == rdata_q[0]) // RULE17
    else $error("lock program verify sense wrong");
  chk_apb_answer: assert property (apb_setup |=> pready && (pslverr == !$past(mapped)))
    else $error("apb answer wrong");
  chk_bank_kept: assert property (!flash.ce_n && !cur.uaddr |-> flash.addr[`FCS_AW-1:12] == addr_q[`FCS_AW-1:12]) // RULE13
    else $error("bank bits lost in command cycle");

endmodule

// [test/fcs_flash_model.sv]
// flash stand-in: follows a few command bytes and answers read cycles
// assumes the host pin bundle of fcs_pkg; reads need oe_n and ce_n low
`timescale 1ns/100ps
module fcs_flash_model
  import fcs_pkg::*;
#(
  parameter logic [15:0] ID_WORD = 16'h3C5A  // arbitrary value
) (
  // host pins
  input  wire fcs_pins_t   pins,
  input  wire logic        lock_ok,
  output logic [15:0]      dq
);
  logic        id_q;
  logic [7:0]  prev_q;
  logic [15:0] last_q;
  wire  [15:0] rd_val = id_q ? ID_WORD : {pins.addr[14:0], lock_ok};
  initial begin
    id_q = 1'b0;
    prev_q = 8'h00;
    last_q = 16'h0000;
  end
  // low data byte taken at the rising write strobe
  always @(posedge pins.we_n) begin
    if (pins.dq_o[7:0] == 8'h90 && prev_q == 8'h55 && pins.addr[11:0] == 12'h555)
      id_q = 1'b1;
    if (pins.dq_o[7:0] == 8'hF0) id_q = 1'b0;
    prev_q = pins.dq_o[7:0];
  end
  // released bus shows the inverse, so a late sample cannot pass by luck
  always @(posedge pins.oe_n) last_q = rd_val;
  assign dq = (!pins.oe_n && !pins.ce_n) ? rd_val : ~last_q;
endmodule

// [test/fcs_host_tb_top.sv]
// bench for the flash command sequencer host: apb driver and pin monitor
// assumes fcs_flash_model on the pins and the map of fcs_regs.svh
`timescale 1ns/100ps
`include "fcs_regs.svh"
module fcs_host_tb_top
  import fcs_pkg::*;
;
  localparam logic [15:0] ID_W = 16'h3C5A;  // arbitrary value
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, lock_ok, err_s;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, st;
  logic [15:0] dq, d;
  logic [21:0] a;
  logic [38:0] ent;
  logic [38:0] exp_q[$];
  fcs_pins_t   flash;
  int          errors, total_checks, seed;
  fcs_host #(.LOCK_CYC(20), .PPBER_CYC(40)) fcs_host_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash(flash), .flash_dq_i(dq));
  fcs_flash_model #(.ID_WORD(ID_W)) fcs_flash_model_i (.pins(flash), .lock_ok(lock_ok), .dq(dq));
  always #2 pclk = ~pclk;
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one apb transfer; waits for pready however long it takes
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err_s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [11:0] lo, input logic [7:0] c);
    exp_q.push_back({1'b0, a[21:12], lo, 8'h00, c});
  endtask
  task automatic full(input logic [15:0] x);
    exp_q.push_back({1'b0, a, x});
  endtask
  // notes the expected pin writes of op, starts it, waits until idle
  task automatic run(input logic [3:0] op, input logic twice);
    apb(1'b1, `FCS_REG_ADDR, {10'h0, a});
    apb(1'b1, `FCS_REG_DATA, {16'h0, d});
    if (op inside {1, 2, 3, 7, 10, 12, 13, 14, 15}) cmd(12'h555, 8'hAA);
    if (op inside {1, 2, 3, 7, 10, 12, 13, 14, 15}) cmd(12'h2AA, 8'h55);
    case (op)
      4'h0: exp_q.push_back({1'b1, 22'h0, 16'h00F0});
      4'h1: begin cmd(12'h555, 8'hA0); full(d); end
      4'h2, 4'h3: begin cmd(12'h555, 8'h80); cmd(12'h555, 8'hAA); cmd(12'h2AA, 8'h55); end
      4'h4: full(16'h00B0);
      4'h5: full(16'h0030);
      4'h6: cmd(12'h055, 8'h98);
      4'h7: cmd(12'h555, 8'h20);
      4'h8: begin exp_q.push_back({1'b1, 22'h0, 16'h00A0}); full(d); end
      4'h9: begin exp_q.push_back({1'b1, 22'h0, 16'h0090}); exp_q.push_back({1'b1, 22'h0, 16'h0000}); end
      4'hA: cmd(12'h555, 8'h90);
      4'hC: begin cmd(12'h555, 8'h60); full(16'h0068); full(16'h0048); end
      4'hD: begin cmd(12'h555, 8'h60); full(16'h0060); full(16'h0040); end
      4'hE: cmd(12'h555, 8'h58);
      4'hF: begin cmd(12'h555, 8'h38); full(d); end
      default: ;
    endcase
    if (op == 4'h2) cmd(12'h555, 8'h10);
    if (op == 4'h3) full(16'h0030);
    apb(1'b1, `FCS_REG_CTRL, 32'h100 | op);
    if (twice) apb(1'b1, `FCS_REG_CTRL, 32'h100 | op);
    for (int i = 0; i < 3000; i++) begin
      apb(1'b0, `FCS_REG_STATUS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    st = rd;
    check("busy", 32'h0, st[0]);
    check("done", 32'h1, st[3]);
    if (twice) check("refused", 32'h1, st[2]);
    if (op == 4'hC) check("verify", lock_ok, st[1]);
    if (op == 4'hD) check("verify", !lock_ok, st[1]);
    apb(1'b1, `FCS_REG_STATUS, 32'hC);
    apb(1'b0, `FCS_REG_RDATA, 32'h0);
    if (op == 4'hA) check("ident word", ID_W, rd);
    if (op inside {11, 14}) check("read word", {a[14:0], lock_ok}, rd);
  endtask
  // each rise of the write strobe is one command cycle, judged against the oldest note
  always @(posedge flash.we_n) if (presetn === 1'b1) begin
    if (exp_q.size() == 0) check("extra write", 32'h0, 32'h1);
    else begin
      ent = exp_q.pop_front();
      check("write addr", ent[38] ? 22'h0 : ent[37:16], ent[38] ? 22'h0 : flash.addr);
      check("write data", ent[15:0], flash.dq_o);
    end
  end
  initial begin
    #400000;
    errors++;
    complete_run();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, lock_ok, paddr, pwdata} = '0;
    {errors, total_checks, a, d} = '0;
    seed = 71;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h0FC, 32'h0);
    check("unmapped err", 32'h1, err_s);
    check("unmapped data", 32'h0, rd);
    for (int k = 0; k < 32; k++) begin
      a = $random(seed);
      d = $random(seed);
      lock_ok <= $random(seed);
      run(k[3:0], 1'b0);
      if (k[3:0] == 4'hA) run(4'h0, 1'b0);
    end
    run(4'h2, 1'b1);
    check("pending writes", 32'h0, exp_q.size());
    complete_run();
  end
endmodule
